// file: core/sector_protect_lock_ctrl.sv
// sector protection bits, lock bit and hardware lock with serial status write and sector protection read
`timescale 1ns/100ps
module sector_protect_lock_ctrl #(
  parameter int NUM_SECTORS = sector_lock_pkg::NUM_SECTORS_DEF
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire sector_lock_pkg::pin_in_t pins_in,
  input wire sector_lock_pkg::sector_cmd_t sector_cmd,
  output sector_lock_pkg::pin_out_t pins_out,
  output logic [NUM_SECTORS-1:0] sector_prot,
  output logic protection_lock_bit,
  output logic hw_lock,
  output logic [7:0] status_view,
  output logic sector_cmd_refused
);
  import sector_lock_pkg::*;

  typedef struct packed {
    pin_in_t meta;
    pin_in_t sync;
    logic sck_prev;
    phase_t phase;
    logic [4:0] bit_cnt;
    logic [ADDR_W-1:0] sh;
    logic [SECT_IDX_W-1:0] rd_sector;
    logic [2:0] out_idx;
    logic [NUM_SECTORS-1:0] sectors;
    logic lock;
    logic hw_lock;
    logic [7:0] status;
    logic so;
    logic so_oe;
    logic refused;
  } state_t;

  state_t s_q;
  state_t s_d;

  // protection bit of one sector; indexes beyond the array read as unprotected
  function automatic logic sector_bit(input logic [NUM_SECTORS-1:0] bits,
                                      input logic [SECT_IDX_W-1:0] idx);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_SECTORS; i++) begin
      if (idx == SECT_IDX_W'(i)) begin
        r = bits[i];
      end
    end
    return r;
  endfunction : sector_bit

  always_comb begin
    logic rise;
    logic fall;
    logic wp_asserted;
    logic hw_now;
    logic [7:0] byte_in;
    logic [ADDR_W-1:0] addr_in;
    logic [7:0] spr_byte;
    logic [2:0] idx_next;
    logic [1:0] summary;
    s_d = s_q;
    s_d.meta = pins_in;
    s_d.sync = s_q.meta;
    s_d.sck_prev = s_q.sync.sck;
    s_d.refused = 1'b0;
    rise = s_q.sync.sck & ~s_q.sck_prev;
    fall = ~s_q.sync.sck & s_q.sck_prev;
    wp_asserted = ~s_q.sync.wp_n;
    hw_now = wp_asserted & s_q.lock;
    addr_in = {s_q.sh[ADDR_W-2:0], s_q.sync.si};
    byte_in = addr_in[7:0];
    spr_byte = SPR_BYTE_CLR;
    summary = SUM_NONE;
    idx_next = s_q.out_idx + 3'h1;

    // per-sector requests: refused under any lock, software or hardware
    if (sector_cmd.valid) begin
      if (s_q.lock) begin
        s_d.refused = 1'b1;
      end else begin
        for (int i = 0; i < NUM_SECTORS; i++) begin
          if (sector_cmd.index == SECT_IDX_W'(i)) begin
            s_d.sectors[i] = sector_cmd.protect;
          end
        end
      end
    end

    if (s_q.sync.cs_n) begin
      // deselect ends any transfer at once, even mid-byte
      s_d.phase = ST_OPCODE;
      s_d.bit_cnt = 5'h00;
      s_d.so_oe = 1'b0;
      s_d.so = 1'b0;
    end else begin
      unique case (s_q.phase)
        ST_OPCODE: begin
          if (rise) begin
            s_d.sh = addr_in;
            s_d.bit_cnt = s_q.bit_cnt + 5'h01;
            if (s_q.bit_cnt == OPCODE_BITS - 5'h01) begin
              s_d.bit_cnt = 5'h00;
              if (byte_in == OP_READ_SECT_PROT) begin
                s_d.phase = ST_ADDR;
              end else if (byte_in == OP_WRITE_STATUS) begin
                s_d.phase = ST_STATUS_DATA;
              end else begin
                s_d.phase = ST_IGNORE;
              end
            end
          end
        end
        ST_ADDR: begin
          if (rise) begin
            s_d.sh = addr_in;
            s_d.bit_cnt = s_q.bit_cnt + 5'h01;
            if (s_q.bit_cnt == ADDR_BITS - 5'h01) begin
              // any address inside the sector selects it
              s_d.rd_sector = addr_in[SECTOR_SHIFT +: SECT_IDX_W];
              s_d.phase = ST_SPR_OUT;
              // first detected fall wraps the index to 0 and re-presents bit 7 to the host
              s_d.out_idx = 3'h7;
              s_d.so_oe = 1'b1;
              spr_byte = sector_bit(s_q.sectors, addr_in[SECTOR_SHIFT +: SECT_IDX_W])
                         ? SPR_BYTE_SET : SPR_BYTE_CLR;
              s_d.so = spr_byte[7];
            end
          end
        end
        ST_SPR_OUT: begin
          // new bit on each falling edge; value does not look at the pin
          if (fall) begin
            spr_byte = sector_bit(s_q.sectors, s_q.rd_sector)
                       ? SPR_BYTE_SET : SPR_BYTE_CLR;
            s_d.out_idx = idx_next;
            s_d.so = spr_byte[3'h7 - idx_next];
          end
        end
        ST_STATUS_DATA: begin
          if (rise) begin
            s_d.sh = addr_in;
            s_d.bit_cnt = s_q.bit_cnt + 5'h01;
            if (s_q.bit_cnt == DATA_BITS - 5'h01) begin
              s_d.phase = ST_IGNORE;
              // pin level as synchronised in the cycle the last data bit lands
              if (!hw_now) begin
                s_d.lock = byte_in[LOCK_BIT_POS];
                if (!s_q.lock) begin
                  if (byte_in[GLOBAL_MSB:GLOBAL_LSB] == GLOBAL_SET_CODE) begin
                    s_d.sectors = '1;
                  end else if (byte_in[GLOBAL_MSB:GLOBAL_LSB] == GLOBAL_CLR_CODE) begin
                    s_d.sectors = '0;
                  end
                end
              end
            end
          end
        end
        ST_IGNORE: begin
          s_d.phase = ST_IGNORE;
        end
      endcase
    end

    if (&s_d.sectors) begin
      summary = SUM_ALL;
    end else if (|s_d.sectors) begin
      summary = SUM_SOME;
    end else begin
      summary = SUM_NONE;
    end
    s_d.hw_lock = wp_asserted & s_d.lock;
    // written values of bits 5..2 are never stored, only live state shows
    s_d.status = 8'h00;
    s_d.status[LOCK_BIT_POS] = s_d.lock;
    s_d.status[WPP_POS] = s_q.sync.wp_n;
    s_d.status[SUMMARY_LSB +: 2] = summary;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.meta.cs_n <= 1'b1;
      s_q.sync.cs_n <= 1'b1;
      s_q.meta.wp_n <= 1'b1;
      s_q.sync.wp_n <= 1'b1;
      s_q.phase <= ST_OPCODE;
      s_q.sectors <= {NUM_SECTORS{SECTOR_RESET}};
      s_q.lock <= LOCK_RESET;
      s_q.status <= 8'h00 | (8'(SUM_ALL) << SUMMARY_LSB) | (8'h01 << WPP_POS);
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // sectors are protected exactly where their bit is set
  assign sector_prot = s_q.sectors;
  assign protection_lock_bit = s_q.lock;
  assign hw_lock = s_q.hw_lock;
  assign status_view = s_q.status;
  assign sector_cmd_refused = s_q.refused;
  assign pins_out.so = s_q.so;
  assign pins_out.so_oe = s_q.so_oe;

endmodule : sector_protect_lock_ctrl

// file: core/sector_lock_pkg.sv
// constants, carriers and state enumeration for the sector protection lock block
package sector_lock_pkg;

  // sector geometry: sector index taken from address bits above SECTOR_SHIFT
  localparam int SECT_IDX_W = 4;
  localparam int NUM_SECTORS_DEF = 16;
  localparam int ADDR_W = 24;
  localparam int SECTOR_SHIFT = 16;

  // serial opcodes
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_SECT_PROT = 8'h3C;

  // repeating answer byte of the sector protection read
  localparam logic [7:0] SPR_BYTE_SET = 8'hFF;
  localparam logic [7:0] SPR_BYTE_CLR = 8'h00;

  // decode of written bits 5..2 while the lock bit is clear
  localparam int GLOBAL_MSB = 5;
  localparam int GLOBAL_LSB = 2;
  localparam logic [3:0] GLOBAL_SET_CODE = 4'hF;
  localparam logic [3:0] GLOBAL_CLR_CODE = 4'h0;

  // status byte layout
  localparam int LOCK_BIT_POS = 7;
  localparam int WPP_POS = 4;
  localparam int SUMMARY_LSB = 2;
  localparam logic [1:0] SUM_NONE = 2'h0;
  localparam logic [1:0] SUM_SOME = 2'h1;
  localparam logic [1:0] SUM_ALL = 2'h3;

  // values after reset
  localparam logic LOCK_RESET = 1'b0;
  localparam logic SECTOR_RESET = 1'b1;

  // serial bit counts
  localparam logic [4:0] OPCODE_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] DATA_BITS = 5'h08;

  // per-sector protect/unprotect request from the command decoder
  typedef struct packed {
    logic valid;
    logic protect;
    logic [SECT_IDX_W-1:0] index;
  } sector_cmd_t;

  // serial pins coming from the host
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } pin_in_t;

  // serial data output with its enable
  typedef struct packed {
    logic so;
    logic so_oe;
  } pin_out_t;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_SPR_OUT,
    ST_STATUS_DATA,
    ST_IGNORE
  } phase_t;

endpackage : sector_lock_pkg

// file: verification/sector_lock_asserts.sv
// port-level checks of the sector protection lock block
`timescale 1ns/100ps
module sector_lock_asserts #(
  parameter int NUM_SECTORS = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire sector_lock_pkg::pin_in_t pins_in,
  input wire sector_lock_pkg::sector_cmd_t sector_cmd,
  input wire sector_lock_pkg::pin_out_t pins_out,
  input wire logic [NUM_SECTORS-1:0] sector_prot,
  input wire logic protection_lock_bit,
  input wire logic hw_lock,
  input wire logic [7:0] status_view,
  input wire logic sector_cmd_refused
);
  import sector_lock_pkg::*;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_deselected;
    pins_in.cs_n [*4];
  endsequence
  a_lock_shown: assert property (status_view[7] == protection_lock_bit)
    else $error("lock bit not shown");
  a_hw_lock_def: assert property (hw_lock == (protection_lock_bit && !status_view[4]))
    else $error("hardware lock wrong");
  a_soft_freeze: assert property ($past(protection_lock_bit) |-> $stable(sector_prot))
    else $error("sectors changed while locked");
  a_hw_keeps_lock: assert property ($past(hw_lock) |-> protection_lock_bit)
    else $error("lock cleared under hardware lock");
  a_refuse_pulse: assert property (sector_cmd.valid && clk_en && protection_lock_bit
    |=> sector_cmd_refused)
    else $error("locked command not refused");
  a_refuse_cause: assert property (sector_cmd_refused
    |-> $past(sector_cmd.valid) && $past(protection_lock_bit))
    else $error("refusal without cause");
  a_sector_apply: assert property (sector_cmd.valid && clk_en && !protection_lock_bit
    && pins_in.cs_n |=> sector_prot[$past(sector_cmd.index)] == $past(sector_cmd.protect))
    else $error("sector command not applied");
  a_summary_code: assert property ($stable(sector_prot) [*2] |-> status_view[3:2] ==
    (&sector_prot ? SUM_ALL : (|sector_prot ? SUM_SOME : SUM_NONE)))
    else $error("summary wrong");
  a_read_steady: assert property (pins_out.so_oe && $past(pins_out.so_oe)
    |-> $stable(pins_out.so))
    else $error("answer byte not constant");
  a_deselect_off: assert property (s_deselected |-> !pins_out.so_oe && !pins_out.so)
    else $error("output driven while deselected");
endmodule : sector_lock_asserts

// file: verification/spi_host_model.sv
// host serial controller driving the block pins
`timescale 1ns/100ps
module spi_host_model (
  input wire logic sys_clk,
  input wire sector_lock_pkg::pin_out_t pins_out,
  output sector_lock_pkg::pin_in_t pins
);
  import sector_lock_pkg::*;
  initial pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins.si <= tx[i];
      tick(16);
      pins.sck <= 1'b1;
      tick(16);
      rx[i] = pins_out.so;
      pins.sck <= 1'b0;
    end
  endtask : xfer
  task automatic frame(input logic [7:0] op, input logic [31:0] body, input int n,
                       output logic [7:0] rx);
    logic [7:0] d;
    pins.cs_n <= 1'b0;
    tick(16);
    xfer(op, d);
    for (int k = n - 1; k >= 0; k--) xfer(body[8*k +: 8], rx);
    tick(16);
    pins.cs_n <= 1'b1;
    tick(8);
  endtask : frame
  task automatic wsr(input logic [7:0] v);
    logic [7:0] d;
    frame(OP_WRITE_STATUS, {24'h000000, v}, 1, d);
  endtask : wsr
  task automatic rdp(input logic [23:0] a, output logic [7:0] rx);
    frame(OP_READ_SECT_PROT, {a, 8'h00}, 4, rx);
  endtask : rdp
  task automatic set_wp(input logic v);
    pins.wp_n <= v;
    tick(8);
  endtask : set_wp
endmodule : spi_host_model

// file: verification/testbench.sv
// self-checking bench of the sector protection lock block
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
module testbench;
  import sector_lock_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  sector_cmd_t sector_cmd = '0;
  pin_in_t pins_in;
  pin_out_t pins_out;
  logic [15:0] sector_prot;
  logic protection_lock_bit, hw_lock, sector_cmd_refused;
  logic [7:0] status_view, rx;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  sector_protect_lock_ctrl #(.NUM_SECTORS(16)) dut (.sys_clk, .reset_n, .clk_en, .pins_in,
    .sector_cmd, .pins_out, .sector_prot, .protection_lock_bit, .hw_lock, .status_view,
    .sector_cmd_refused);
  spi_host_model host (.sys_clk, .pins_out, .pins(pins_in));
  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] sp, input logic [7:0] sv);
    #1;
    `CHK(sector_prot, sp)
    `CHK(protection_lock_bit, sv[7])
    `CHK(hw_lock, sv[7] & ~sv[4])
    `CHK(status_view, sv)
  endtask : chk
  task automatic cmd(input logic p, input logic [3:0] idx, input logic ref_e);
    @(posedge sys_clk);
    sector_cmd <= '{valid: 1'b1, protect: p, index: idx};
    @(posedge sys_clk);
    sector_cmd <= '0;
    #1;
    `CHK(sector_cmd_refused, ref_e)
  endtask : cmd
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    host.tick(4);
    chk(16'hFFFF, 8'h1C);
    host.wsr(8'h00);
    chk(16'h0000, 8'h10);
    host.rdp(24'h05ABCD, rx);
    `CHK(rx, SPR_BYTE_CLR)
    cmd(1'b1, 4'h3, 1'b0);
    chk(16'h0008, 8'h14);
    clk_en <= 1'b0;
    cmd(1'b0, 4'h3, 1'b0);
    chk(16'h0008, 8'h14);
    clk_en <= 1'b1;
    host.rdp(24'h03FFFF, rx);
    `CHK(rx, SPR_BYTE_SET)
    host.wsr(8'h7F);
    chk(16'hFFFF, 8'h1C);
    host.wsr(8'h00);
    cmd(1'b1, 4'h3, 1'b0);
    host.wsr(8'hF0);
    chk(16'h0008, 8'h94);
    cmd(1'b1, 4'h4, 1'b1);
    host.wsr(8'h3C);
    chk(16'h0008, 8'h14);
    host.wsr(8'hFF);
    chk(16'hFFFF, 8'h9C);
    host.wsr(8'h0F);
    chk(16'hFFFF, 8'h1C);
    host.wsr(8'hF0);
    host.set_wp(1'b0);
    chk(16'hFFFF, 8'h8C);
    host.wsr(8'h00);
    chk(16'hFFFF, 8'h8C);
    host.rdp(24'h000000, rx);
    `CHK(rx, SPR_BYTE_SET)
    reset_n <= 1'b0;
    host.tick(6);
    reset_n <= 1'b1;
    host.tick(4);
    chk(16'hFFFF, 8'h0C);
    report_and_stop();
  end
endmodule : testbench
bind sector_protect_lock_ctrl sector_lock_asserts #(.NUM_SECTORS(NUM_SECTORS)) u_chk (
  .sys_clk, .reset_n, .clk_en, .pins_in, .sector_cmd, .pins_out, .sector_prot,
  .protection_lock_bit, .hw_lock, .status_view, .sector_cmd_refused);
